/* File: nvsc_regs.svh */
`ifndef NVSC_REGS_SVH
`define NVSC_REGS_SVH

`define NVSC_SEQ_A0 11'h000
`define NVSC_SEQ_A1 11'h555
`define NVSC_SEQ_A2 11'h2AA
`define NVSC_SEQ_A3 11'h7FF
`define NVSC_SEQ_A4 11'h0F0
`define NVSC_SEQ_STORE 11'h70F
`define NVSC_SEQ_RECALL 11'h70E
`define NVSC_SEQ_TEST 11'h39C
`define NVSC_SEQ_LEN 3'h6
`define NVSC_STEP_W 3
`define NVSC_CLK_MHZ 50
`define NVSC_CLK_NS 20
`define NVSC_SLOT_NS 60
`define NVSC_CE_LOW_NS 60
`define NVSC_STORE_MS 10
`define NVSC_RECALL_US 20
`define NVSC_RESTORE_US 650
`define NVSC_SLOT_CYC ((`NVSC_SLOT_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_CE_CYC ((`NVSC_CE_LOW_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_STORE_CYC (`NVSC_STORE_MS * 1000 * `NVSC_CLK_MHZ)
`define NVSC_RECALL_CYC (`NVSC_RECALL_US * `NVSC_CLK_MHZ)
`define NVSC_RESTORE_CYC (`NVSC_RESTORE_US * `NVSC_CLK_MHZ)
`define NVSC_CNT_W 20

`endif

/* File: nvsc_pkg.sv */
package nvsc_pkg;
    typedef enum logic [3:0] {
        NVSC_POWERUP, NVSC_IDLE, NVSC_SETUP, NVSC_STROBE, NVSC_HOLD, NVSC_BUSY
    } nvsc_state_t;
    typedef enum logic [1:0] {NVSC_OP_READ, NVSC_OP_WRITE, NVSC_OP_STORE, NVSC_OP_RECALL} nvsc_op_t;
endpackage : nvsc_pkg

/* File: nvsc_seq_rom.sv */
`timescale 1ns/100ps
`include "nvsc_regs.svh"
// sequence address table; output registered so the caller sees it one cycle after the index
module nvsc_seq_rom (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] idx,
    input wire logic recall,
    output logic [10:0] addr_q
);
    logic [10:0] addr_d;
    // last entry picks the transfer kind; the reserved test address is never produced
    always_comb begin
        case (idx)
            3'h0: addr_d = `NVSC_SEQ_A0;
            3'h1: addr_d = `NVSC_SEQ_A1;
            3'h2: addr_d = `NVSC_SEQ_A2;
            3'h3: addr_d = `NVSC_SEQ_A3;
            3'h4: addr_d = `NVSC_SEQ_A4;
            default: addr_d = recall ? `NVSC_SEQ_RECALL : `NVSC_SEQ_STORE; // RULE8 RULE9 RULE24
        endcase
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addr_q <= 11'h000;
        end else begin
            addr_q <= addr_d;
        end
    end
endmodule : nvsc_seq_rom

/* File: nvsc_host.sv */
`timescale 1ns/100ps
`include "nvsc_regs.svh"
//Contract
//RULE1: reads happen with chip enable and output enable low, write strobe high.
//RULE2: eleven byte select lines pick one of 2048 bytes.
//RULE3: read data stays driven until address or controls change.
//RULE4: write happens with chip enable and strobe low; latched at first rise.
//RULE5: host holds address stable through the whole write.
//RULE6: device floats its drivers if output enable stays low in a write.
//RULE7: host keeps output enable high during writes.
//RULE8: reads of 000,555,2AA,7FF,0F0,70F start a store.
//RULE9: same first five then 70E start a recall.
//RULE10: any other access inside the sequence aborts it.
//RULE11: host keeps write strobe high during sequence chip enable pulses.
//RULE12: sequence works with output enable high or low.
//RULE13: every sequence step is a separate chip enable pulse.
//RULE14: after step six device ignores inputs and floats within 600 ns.
//RULE15: store finishes within 10 ms, then SRAM is usable again.
//RULE16: store erases then programs all cells from SRAM.
//RULE17: recall clears SRAM, copies EEPROM, within 20 us.
//RULE18: a 20 ns chip enable pulse still registers a step.
//RULE19: chip enable glitches repeat reads and abort the sequence.
//RULE20: power-up recall blocks SRAM access until reload time passes.
//RULE21: low supply inhibits or aborts stores, not recalls.
//RULE22: host must not hold a write when power-up recall ends.
//RULE23: power-up recall lasts at most 650 us.
//RULE24: host never issues the reserved test sixth address 39C.
//RULE25: step counter advances on matches, resets on mismatch or write.
module nvsc_host
    import nvsc_pkg::*;
#(
    parameter int STORE_CYC = `NVSC_STORE_CYC,
    parameter int RESTORE_CYC = `NVSC_RESTORE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire nvsc_op_t req_op,
    input wire logic [10:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic busy,
    output logic [10:0] byte_select_lines,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe,
    input wire logic [7:0] data_lines_i,
    output logic chip_en_n,
    output logic out_en_n,
    output logic write_en_n
);
    typedef struct packed {
        nvsc_state_t st;
        nvsc_op_t op;
        logic [2:0] step;
        logic [`NVSC_CNT_W-1:0] cnt;
        logic [10:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic rsp;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic drive;
    } nvsc_regs_t;

    nvsc_regs_t s_q, s_d;
    logic [7:0] din_m_q, din_s_q;
    logic [10:0] seq_addr;
    logic seq_op;

    assign seq_op = (s_q.op == NVSC_OP_STORE) || (s_q.op == NVSC_OP_RECALL);

    // table fed with the next step, so its registered output matches the step being run
    nvsc_seq_rom u_rom (
        .sys_clk(sys_clk),
        .rst(rst),
        .idx(s_d.step),
        .recall(s_d.op == NVSC_OP_RECALL),
        .addr_q(seq_addr)
    );

    // read data come from the pins, so two flops before use
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            din_m_q <= 8'h00;
            din_s_q <= 8'h00;
        end else begin
            din_m_q <= data_lines_i;
            din_s_q <= din_m_q;
        end
    end

    // single sequencer for plain accesses and the six-step transfer sequence
    always_comb begin
        s_d = s_q;
        s_d.rsp = 1'b0;
        case (s_q.st)
            NVSC_POWERUP: begin
                s_d.we_n = 1'b1; // RULE22
                if (s_q.cnt >= `NVSC_CNT_W'(RESTORE_CYC - 1)) begin // RULE20 RULE23
                    s_d.st = NVSC_IDLE;
                    s_d.cnt = '0;
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            NVSC_IDLE: begin
                if (req_valid) begin
                    s_d.op = req_op;
                    s_d.addr = req_addr;
                    s_d.wdata = req_wdata;
                    s_d.step = 3'h0; // RULE25
                    s_d.cnt = '0;
                    s_d.st = NVSC_SETUP;
                end
            end
            NVSC_SETUP: begin
                // address set up with all strobes high; one cycle for the table lookup
                if (seq_op) begin
                    s_d.addr = seq_addr; // RULE8 RULE9
                end
                s_d.ce_n = 1'b0; // RULE13
                s_d.we_n = (s_q.op != NVSC_OP_WRITE); // RULE11
                s_d.oe_n = (s_q.op != NVSC_OP_READ); // RULE7 RULE12
                s_d.drive = (s_q.op == NVSC_OP_WRITE);
                s_d.cnt = '0;
                s_d.st = NVSC_STROBE;
            end
            NVSC_STROBE: begin
                // pulse wider than any access time, so reads are valid and steps count
                if (s_q.cnt >= `NVSC_CNT_W'(`NVSC_CE_CYC - 1)) begin // RULE18
                    s_d.rdata = din_s_q; // RULE1 RULE3
                    s_d.ce_n = 1'b1; // RULE4
                    s_d.we_n = 1'b1;
                    s_d.oe_n = 1'b1;
                    s_d.cnt = '0;
                    s_d.st = NVSC_HOLD;
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            NVSC_HOLD: begin
                // address and data held one cycle past the strobe release
                s_d.drive = 1'b0; // RULE5
                if (seq_op && s_q.step != `NVSC_SEQ_LEN - 3'h1) begin
                    s_d.step = s_q.step + 3'h1; // RULE10 RULE19 RULE25
                    s_d.st = NVSC_SETUP;
                end else if (seq_op) begin
                    s_d.cnt = '0;
                    s_d.st = NVSC_BUSY; // RULE14
                end else begin
                    s_d.rsp = 1'b1;
                    s_d.st = NVSC_IDLE;
                end
            end
            NVSC_BUSY: begin
                // device ignores pins now; wait out the worst-case transfer time
                if (s_q.cnt >= ((s_q.op == NVSC_OP_STORE) ? `NVSC_CNT_W'(STORE_CYC - 1)
                        : `NVSC_CNT_W'(`NVSC_RECALL_CYC - 1))) begin // RULE15 RULE16 RULE17
                    s_d.rsp = 1'b1;
                    s_d.st = NVSC_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            default: begin
                s_d.st = NVSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '{st: NVSC_POWERUP, op: NVSC_OP_READ, step: 3'h0, cnt: '0,
                     addr: 11'h000, wdata: 8'h00, rdata: 8'h00, rsp: 1'b0,
                     ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, drive: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready = (s_q.st == NVSC_IDLE);
    assign busy = (s_q.st == NVSC_POWERUP) || (s_q.st == NVSC_BUSY); // RULE21
    assign rsp_valid = s_q.rsp;
    assign rsp_rdata = s_q.rdata;
    // sequence addresses come straight from the table flop; they move only while chip enable is high
    assign byte_select_lines = seq_op ? seq_addr : s_q.addr; // RULE2 RULE8 RULE9
    assign data_lines_o = s_q.wdata;
    assign data_lines_oe = s_q.drive; // RULE6
    assign chip_en_n = s_q.ce_n;
    assign out_en_n = s_q.oe_n;
    assign write_en_n = s_q.we_n;

    oe_in_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        !write_en_n |-> out_en_n) else $error("output enable low during write"); // RULE7
    addr_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!chip_en_n && !write_en_n) |=> $stable(byte_select_lines)) // RULE5
        else $error("address moved during write");
    seq_no_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        (seq_op && !chip_en_n) |-> write_en_n) else $error("write inside sequence"); // RULE11
    ce_width_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(chip_en_n) |-> !chip_en_n [*3]) else $error("chip enable pulse short"); // RULE18
    seq_one_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(chip_en_n) && seq_op |-> chip_en_n [*2]) // RULE13
        else $error("chip enable not released between steps");
    busy_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        busy |-> chip_en_n && write_en_n && !data_lines_oe) // RULE14
        else $error("pins active while device busy");
    no_test_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
        !chip_en_n && seq_op && s_q.step == 3'h5 |-> byte_select_lines != `NVSC_SEQ_TEST)
        else $error("reserved test address issued"); // RULE24
    seq_last_a: assert property (@(posedge sys_clk) disable iff (rst)
        !chip_en_n && s_q.op == NVSC_OP_RECALL && s_q.step == 3'h5
        |-> byte_select_lines == `NVSC_SEQ_RECALL) else $error("bad recall address"); // RULE9
    store_last_a: assert property (@(posedge sys_clk) disable iff (rst)
        !chip_en_n && s_q.op == NVSC_OP_STORE && s_q.step == 3'h5
        |-> byte_select_lines == `NVSC_SEQ_STORE) else $error("bad store address"); // RULE8
endmodule : nvsc_host

/* File: nvsc_dev_model.sv */
`timescale 1ns/100ps
// behavioural memory device on the far side of the host pins
module nvsc_dev_model #(
    parameter int STORE_NS = 800,
    parameter int RECALL_NS = 5000,
    parameter int RESTORE_NS = 600
) (
    input wire logic [10:0] byte_select_lines,
    input wire logic [7:0] data_lines_o,
    input wire logic data_lines_oe,
    input wire logic chip_en_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    output logic [7:0] data_lines_i
);
    logic [7:0] sram [0:2047];
    logic [7:0] nv [0:2047];
    logic [7:0] last;
    logic [7:0] stores;
    logic [7:0] recalls;
    logic [7:0] viol;
    logic dev_busy;
    logic in_wr;
    logic [2:0] step;
    logic [10:0] seq [0:4] = '{11'h000, 11'h555, 11'h2AA, 11'h7FF, 11'h0F0};
    logic dev_drv;
    // outputs only while selected for a read and idle; floats during a write
    assign dev_drv = !dev_busy && !chip_en_n && !out_en_n && write_en_n;
    // a released line shows the inverse of its last value, never a stale copy
    assign data_lines_i = data_lines_oe ? data_lines_o : (dev_drv ? sram[byte_select_lines] : ~last);
    always @(data_lines_i) begin
        if (data_lines_oe || dev_drv) last = data_lines_i;
    end
    // erase then copy every cell in one go, after the transfer time
    task automatic xfer(input logic to_nv, input int ns);
        dev_busy = 1'b1;
        #(ns);
        for (int i = 0; i < 2048; i++) begin
            if (to_nv) nv[i] = 8'h00;
            if (to_nv) nv[i] = sram[i];
            if (!to_nv) sram[i] = 8'h00;
            if (!to_nv) sram[i] = nv[i];
        end
        dev_busy = 1'b0;
    endtask : xfer
    // known nonvolatile pattern, reloaded by the power-up recall
    initial begin
        for (int i = 0; i < 2048; i++) nv[i] = i[7:0] ^ 8'hA5;
        last = 8'h00;
        stores = 8'h00;
        recalls = 8'h00;
        viol = 8'h00;
        step = 3'h0;
        in_wr = 1'b0;
        xfer(1'b0, RESTORE_NS);
        if (in_wr) viol = viol + 8'h01;
    end
    // sequence steps are clocked by chip enable falls only; output enable is ignored
    always @(negedge chip_en_n) begin
        if (dev_busy) viol = viol + 8'h01;
        else if (write_en_n && step == 3'h5 && byte_select_lines[10:1] == 10'h387) begin
            step = 3'h0;
            if (byte_select_lines[0]) stores = stores + 8'h01;
            else recalls = recalls + 8'h01;
            fork
                xfer(byte_select_lines[0], byte_select_lines[0] ? STORE_NS : RECALL_NS);
            join_none
        end else if (write_en_n && step < 3'h5 && byte_select_lines == seq[step]) step = step + 3'h1;
        else step = (byte_select_lines == 11'h000) ? 3'h1 : 3'h0;
    end
    // write runs while both strobes are low and latches at the first rise
    always @(chip_en_n, write_en_n) begin
        if (!chip_en_n && !write_en_n && !dev_busy) in_wr = 1'b1;
        else if (in_wr) begin
            sram[byte_select_lines] = data_lines_i;
            step = 3'h0;
            in_wr = 1'b0;
        end
    end
    // address moves or output enable low inside a write are host faults
    always @(byte_select_lines, out_en_n) begin
        if (in_wr) viol = viol + 8'h01;
    end
endmodule : nvsc_dev_model

/* File: test_nvsc_host.sv */
`timescale 1ns/100ps
module test_nvsc_host
    import nvsc_pkg::*;
();
    typedef struct {nvsc_op_t op; logic [10:0] a; logic [7:0] d; logic [7:0] e;} nvsc_row_t;
    logic sys_clk, rst, req_valid, req_ready, rsp_valid, busy;
    logic data_lines_oe, chip_en_n, out_en_n, write_en_n;
    nvsc_op_t req_op;
    logic [10:0] req_addr, byte_select_lines;
    logic [7:0] req_wdata, rsp_rdata, data_lines_o, data_lines_i;
    int err_total = 0;
    int checks_done = 0;
    // power-up content first, then back-to-back write and read-back
    nvsc_row_t rows [6] = '{'{NVSC_OP_READ, 11'h000, 8'h00, 8'hA5},
        '{NVSC_OP_READ, 11'h7FF, 8'h00, 8'h5A}, '{NVSC_OP_WRITE, 11'h7FF, 8'h3C, 8'h00},
        '{NVSC_OP_READ, 11'h7FF, 8'h00, 8'h3C}, '{NVSC_OP_WRITE, 11'h555, 8'hC3, 8'h00},
        '{NVSC_OP_READ, 11'h555, 8'h00, 8'hC3}};
    nvsc_host #(.STORE_CYC(50), .RESTORE_CYC(40)) u_nvsc_host (.sys_clk(sys_clk), .rst(rst),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy),
        .byte_select_lines(byte_select_lines), .data_lines_o(data_lines_o),
        .data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i), .chip_en_n(chip_en_n),
        .out_en_n(out_en_n), .write_en_n(write_en_n));
    nvsc_dev_model u_nvsc_dev_model (.byte_select_lines(byte_select_lines),
        .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe), .chip_en_n(chip_en_n),
        .out_en_n(out_en_n), .write_en_n(write_en_n), .data_lines_i(data_lines_i));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // one request held until taken, then a bounded wait for the answer
    task automatic do_req(input nvsc_op_t op, input logic [10:0] a, input logic [7:0] d,
        input logic [7:0] e);
        int n;
        n = 0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        @(negedge sys_clk);
        while (req_ready !== 1'b1 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 3000) begin
            err_total++;
            $display("Error at %0t: request not taken, got %0h expected %0h", $time, 1'b0, 1'b1);
        end
        @(posedge sys_clk);
        req_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 3000) begin
            err_total++;
            $display("Error at %0t: no answer, got %0h expected %0h", $time, 1'b0, 1'b1);
        end
        if (op == NVSC_OP_READ) chk(rsp_rdata, e);
    endtask : do_req
    // free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // hang guard sized well beyond the recall wait
    initial begin
        #200000;
        err_total++;
        $display("Error at %0t: watchdog expired, got %0h expected %0h", $time, 1'b0, 1'b1);
        end_sim();
    end
    // reset, table rows, then store and recall round trip
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_op = NVSC_OP_READ;
        req_addr = 11'h000;
        req_wdata = 8'h00;
        repeat (16) @(posedge sys_clk);
        chk({7'h00, req_ready, busy}, 8'h01);
        chk({5'h00, chip_en_n, out_en_n, write_en_n}, 8'h07);
        rst <= 1'b0;
        $display("test reset done");
        foreach (rows[i]) do_req(rows[i].op, rows[i].a, rows[i].d, rows[i].e);
        $display("test rows done");
        do_req(NVSC_OP_STORE, 11'h000, 8'h00, 8'h00);
        chk(u_nvsc_dev_model.stores, 8'h01);
        do_req(NVSC_OP_WRITE, 11'h7FF, 8'h00, 8'h00);
        do_req(NVSC_OP_WRITE, 11'h123, 8'h77, 8'h00);
        do_req(NVSC_OP_RECALL, 11'h000, 8'h00, 8'h00);
        chk(u_nvsc_dev_model.recalls, 8'h01);
        do_req(NVSC_OP_READ, 11'h7FF, 8'h00, 8'h3C);
        do_req(NVSC_OP_READ, 11'h123, 8'h00, 8'h86);
        chk(u_nvsc_dev_model.viol, 8'h00);
        $display("test store recall done");
        end_sim();
    end
endmodule : test_nvsc_host
